// *** rtl/dlc_regs.sv ***
// register bank for base layer configuration and overlay one channel control
// assumes one clock, synchronous reset, pipeline event pulses on the same clock
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module dlc_regs
  import dlc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire dlc_events_t events,
  input wire logic frameStart,
  input wire logic frameEnd,
  input wire logic headTaken,
  input wire logic [3:0] compWidth,
  input wire dlc_rgb_t pixelIn,
  output logic [31:0] rowStride,
  output logic [3:0] lookupBits,
  output dlc_rgb_t baseColour,
  output logic overlayOn,
  output logic overlayAbort,
  output logic attrApply,
  output logic headRequest,
  output logic irq
);
  logic [1:0] lookupMode_r;
  logic [31:0] rowStride_r;
  dlc_rgb_t defColour_r;
  logic pathSel_r;
  logic replicate_r;
  dlc_chan_t chan_r;
  dlc_chan_t chan_nxt;
  logic attrPending_r;
  logic headPending_r;
  logic abort_r;
  logic overlayOn_r;
  logic attrApply_r;
  logic [IRQ_N-1:0] mask_r;
  logic [IRQ_N-1:0] status_r;
  logic [IRQ_N-1:0] status_nxt;
  logic irq_r;
  logic [31:0] rdata_r;
  logic [3:0] lookupBits_r;
  dlc_rgb_t wide;
  dlc_rgb_t baseColour_r;
  logic wrEnable;
  logic wrDisable;
  logic rdStatus;

  assign wrEnable = regWr && regAddr == OFF_CH_ENABLE;
  assign wrDisable = regWr && regAddr == OFF_CH_DISABLE;
  assign rdStatus = regRd && regAddr == OFF_IRQ_STATUS;

  // base layer configuration storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lookupMode_r <= RST_LOOKUP;
      rowStride_r <= RST_WORD;
      defColour_r <= RST_WORD[23:0];
      pathSel_r <= 1'b0;
      replicate_r <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        OFF_LOOKUP_CFG: lookupMode_r <= regWdata[LOOKUP_MSB:LOOKUP_LSB];
        OFF_ROW_STRIDE: rowStride_r <= regWdata;
        OFF_DEF_COLOUR: defColour_r <= regWdata[23:0];
        OFF_PATH_SEL: begin
          pathSel_r <= regWdata[PATH_BIT];
          replicate_r <= regWdata[REPL_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      lookupBits_r <= 4'h1;
    end else begin
      lookupBits_r <= 4'h1 << lookupMode_r;
    end
  end

  dlc_expand u_expand (
    .clk(clk),
    .rstn(rstn),
    .compWidth(compWidth),
    .replicate(replicate_r),
    .rawIn(pixelIn),
    .wideOut(wide)
  );

  always_ff @(posedge clk) begin
    if (!rstn) begin
      baseColour_r <= RST_WORD[23:0];
    end else begin
      baseColour_r <= pathSel_r ? wide : defColour_r;
    end
  end

  // channel state machine
  always_comb begin
    chan_nxt = chan_r;
    unique case (chan_r)
      CH_OFF: begin
        if (wrEnable && regWdata[CH_ON_BIT]) begin
          chan_nxt = CH_ON;
        end
      end
      CH_ON: begin
        if (wrDisable && regWdata[CH_OFF_BIT]) begin
          chan_nxt = CH_STOPPING;
        end
      end
      CH_STOPPING: begin
        if (frameEnd) begin
          chan_nxt = CH_OFF;
        end
      end
      default: chan_nxt = CH_OFF;
    endcase
    if (wrDisable && regWdata[CH_ABORT_BIT]) begin
      chan_nxt = CH_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      chan_r <= CH_OFF;
      abort_r <= 1'b0;
    end else begin
      chan_r <= chan_nxt;
      abort_r <= wrDisable && regWdata[CH_ABORT_BIT];
    end
  end

  // running flag kept in a flop so the output needs no decode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      overlayOn_r <= 1'b0;
    end else begin
      overlayOn_r <= chan_nxt != CH_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      attrPending_r <= 1'b0;
      attrApply_r <= 1'b0;
    end else begin
      attrApply_r <= attrPending_r && frameStart;
      if (wrEnable && regWdata[ATTR_BIT]) begin
        attrPending_r <= 1'b1;
      end else if (frameStart) begin
        attrPending_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      headPending_r <= 1'b0;
    end else if (wrEnable && regWdata[QHEAD_BIT]) begin
      headPending_r <= 1'b1;
    end else if (headTaken) begin
      headPending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_r <= RST_IRQ;
    end else if (regWr && regAddr == OFF_IRQ_SET) begin
      mask_r <= mask_r | regWdata[IRQ_MSB:IRQ_LSB];
    end else if (regWr && regAddr == OFF_IRQ_CLEAR) begin
      mask_r <= mask_r & ~regWdata[IRQ_MSB:IRQ_LSB];
    end
  end

  // clear on read, new event wins
  always_comb begin
    status_nxt = (rdStatus ? RST_IRQ : status_r) | events;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_r <= RST_IRQ;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // read port, data valid one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= RST_WORD;
    end else begin
      rdata_r <= RST_WORD;
      if (regRd) begin
        unique case (regAddr)
          OFF_LOOKUP_CFG: rdata_r[LOOKUP_MSB:LOOKUP_LSB] <= lookupMode_r;
          OFF_ROW_STRIDE: rdata_r <= rowStride_r;
          OFF_DEF_COLOUR: rdata_r[23:0] <= defColour_r;
          OFF_PATH_SEL: begin
            rdata_r[PATH_BIT] <= pathSel_r;
            rdata_r[REPL_BIT] <= replicate_r;
          end
          OFF_CH_STATE: begin
            rdata_r[CH_ON_BIT] <= chan_r != CH_OFF;
            rdata_r[ATTR_BIT] <= attrPending_r;
            rdata_r[QHEAD_BIT] <= headPending_r;
          end
          OFF_IRQ_MASK: rdata_r[IRQ_MSB:IRQ_LSB] <= mask_r;
          OFF_IRQ_STATUS: rdata_r[IRQ_MSB:IRQ_LSB] <= status_r;
          default: begin
          end
        endcase
      end
    end
  end

  assign regRdata = rdata_r;
  assign rowStride = rowStride_r;
  assign lookupBits = lookupBits_r;
  assign baseColour = baseColour_r;
  assign overlayOn = overlayOn_r;
  assign overlayAbort = abort_r;
  assign attrApply = attrApply_r;
  assign headRequest = headPending_r;
  assign irq = irq_r;

  // checks
  a_depth_decode: assert property (@(posedge clk) disable iff (!rstn)
    ##1 lookupBits_r == (4'h1 << $past(lookupMode_r)))
    else $error("lookup depth decode wrong");
  a_stride_read: assert property (@(posedge clk) disable iff (!rstn)
    regRd && regAddr == OFF_ROW_STRIDE |=> regRdata == $past(rowStride_r))
    else $error("stride readback wrong");
  a_colour_store: assert property (@(posedge clk) disable iff (!rstn)
    regWr && regAddr == OFF_DEF_COLOUR |=> defColour_r.red == $past(regWdata[23:16]))
    else $error("default red misplaced");
  a_default_shown: assert property (@(posedge clk) disable iff (!rstn)
    !pathSel_r |=> baseColour_r == $past(defColour_r))
    else $error("default colour not shown");
  a_enable_start: assert property (@(posedge clk) disable iff (!rstn)
    chan_r == CH_OFF && wrEnable && regWdata[CH_ON_BIT] && !wrDisable |=> overlayOn)
    else $error("enable did not start channel");
  a_attr_hold: assert property (@(posedge clk) disable iff (!rstn)
    attrPending_r && !frameStart |=> attrPending_r)
    else $error("attribute pending dropped early");
  a_attr_apply: assert property (@(posedge clk) disable iff (!rstn)
    attrPending_r && frameStart && !wrEnable |=> attrApply_r && !attrPending_r)
    else $error("attributes not applied at frame start");
  a_head_pend: assert property (@(posedge clk) disable iff (!rstn)
    wrEnable && regWdata[QHEAD_BIT] |=> headPending_r)
    else $error("head request not pending");
  a_head_state: assert property (@(posedge clk) disable iff (!rstn)
    regRd && regAddr == OFF_CH_STATE |=> regRdata[QHEAD_BIT] == $past(headPending_r))
    else $error("head pending readback wrong");
  a_stop_frame: assert property (@(posedge clk) disable iff (!rstn)
    chan_r == CH_STOPPING && !frameEnd && !wrDisable |=> chan_r == CH_STOPPING)
    else $error("layer stopped before frame end");
  a_abort_now: assert property (@(posedge clk) disable iff (!rstn)
    wrDisable && regWdata[CH_ABORT_BIT] |=> !overlayOn && overlayAbort ##1
      (!overlayAbort || $past(wrDisable && regWdata[CH_ABORT_BIT])))
    else $error("abort not immediate");
  a_attr_state: assert property (@(posedge clk) disable iff (!rstn)
    regRd && regAddr == OFF_CH_STATE |=> regRdata[ATTR_BIT] == $past(attrPending_r))
    else $error("attribute pending readback wrong");
  a_mask_set: assert property (@(posedge clk) disable iff (!rstn)
    regWr && regAddr == OFF_IRQ_SET |=>
      (mask_r & $past(regWdata[IRQ_MSB:IRQ_LSB])) == $past(regWdata[IRQ_MSB:IRQ_LSB]))
    else $error("mask set failed");
  a_mask_clear: assert property (@(posedge clk) disable iff (!rstn)
    regWr && regAddr == OFF_IRQ_CLEAR |=> (mask_r & $past(regWdata[IRQ_MSB:IRQ_LSB])) == 5'h00)
    else $error("mask clear failed");
  a_mask_read: assert property (@(posedge clk) disable iff (!rstn)
    regRd && regAddr == OFF_IRQ_MASK |=> regRdata == {25'h0, $past(mask_r), 2'h0})
    else $error("mask readback wrong");
  a_status_clear: assert property (@(posedge clk) disable iff (!rstn)
    rdStatus && events == 5'h00 |=> status_r == 5'h00)
    else $error("status not cleared by read");
  a_status_keep: assert property (@(posedge clk) disable iff (!rstn)
    rdStatus |=> status_r == $past(events))
    else $error("event lost in read cycle");
  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    ##1 irq == |(status_r & $past(mask_r)))
    else $error("interrupt level wrong");
  a_idle_rdata: assert property (@(posedge clk) disable iff (!rstn)
    !regRd |=> regRdata == 32'h00000000)
    else $error("read data outside read slot");

  c_frame_stop: cover property (@(posedge clk) disable iff (!rstn)
    chan_r == CH_STOPPING ##1 chan_r == CH_OFF);
  c_irq_raise: cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
  c_attr_apply: cover property (@(posedge clk) disable iff (!rstn) attrApply_r);
  c_abort_seen: cover property (@(posedge clk) disable iff (!rstn) overlayAbort);
  c_head_taken: cover property (@(posedge clk) disable iff (!rstn)
    headPending_r ##1 !headPending_r);
endmodule : dlc_regs
`default_nettype wire

// *** rtl/dlc_pkg.sv ***
// package for the display layer channel register bank
// shared by dlc_regs and dlc_expand; single clock domain assumed
package dlc_pkg;
  // byte addresses of the registers
  localparam logic [31:0] OFF_LOOKUP_CFG = 32'hF8038070;
  localparam logic [31:0] OFF_ROW_STRIDE = 32'hF8038074;
  localparam logic [31:0] OFF_DEF_COLOUR = 32'hF8038078;
  localparam logic [31:0] OFF_PATH_SEL = 32'hF803807C;
  localparam logic [31:0] OFF_CH_ENABLE = 32'hF8038100;
  localparam logic [31:0] OFF_CH_DISABLE = 32'hF8038104;
  localparam logic [31:0] OFF_CH_STATE = 32'hF8038108;
  localparam logic [31:0] OFF_IRQ_SET = 32'hF803810C;
  localparam logic [31:0] OFF_IRQ_CLEAR = 32'hF8038110;
  localparam logic [31:0] OFF_IRQ_MASK = 32'hF8038114;
  localparam logic [31:0] OFF_IRQ_STATUS = 32'hF8038118;
  // field positions
  localparam int LOOKUP_LSB = 8;
  localparam int LOOKUP_MSB = 9;
  localparam int PATH_BIT = 8;
  localparam int REPL_BIT = 9;
  localparam int CH_ON_BIT = 0;
  localparam int ATTR_BIT = 1;
  localparam int QHEAD_BIT = 2;
  localparam int CH_OFF_BIT = 0;
  localparam int CH_ABORT_BIT = 8;
  localparam int IRQ_LSB = 2;
  localparam int IRQ_MSB = 6;
  localparam int IRQ_N = 5;
  localparam int COMP_W = 8;
  // values after reset, and the full component width
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [IRQ_N-1:0] RST_IRQ = 5'h00;
  localparam logic [1:0] RST_LOOKUP = 2'h0;
  localparam logic [3:0] FULL_WIDTH = 4'h8;

  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
  } dlc_rgb_t;

  // event sources: end of transfer, descriptor, head, end of list, overflow
  typedef struct packed {
    logic overflow;
    logic listEnd;
    logic headLoaded;
    logic descLoaded;
    logic xferEnd;
  } dlc_events_t;

  typedef enum logic [2:0] {
    CH_OFF = 3'h1,
    CH_ON = 3'h2,
    CH_STOPPING = 3'h4
  } dlc_chan_t;
endpackage : dlc_pkg

// *** rtl/dlc_expand.sv ***
// widening of narrow colour components to 8 bits each
// component width comes from the pixel pipeline on the same clock
`timescale 1ns/10ps
`default_nettype none
module dlc_expand
  import dlc_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] compWidth,
  input wire logic replicate,
  input wire dlc_rgb_t rawIn,
  output dlc_rgb_t wideOut
);
  logic [COMP_W-1:0] rawC [3];
  logic [COMP_W-1:0] wideC [3];
  logic [3:0] widthEff;

  // width 0 or above 8 is taken as full width
  assign widthEff = (compWidth == 4'h0 || compWidth > FULL_WIDTH) ? FULL_WIDTH : compWidth;
  assign rawC[0] = rawIn.red;
  assign rawC[1] = rawIn.green;
  assign rawC[2] = rawIn.blue;

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_comp
      logic [COMP_W-1:0] shifted;
      logic [COMP_W-1:0] lowMask;
      logic msb;
      assign shifted = rawC[c] << (FULL_WIDTH - widthEff);
      assign lowMask = 8'hFF >> widthEff;
      assign msb = shifted[COMP_W-1];
      always_ff @(posedge clk) begin
        if (!rstn) begin
          wideC[c] <= 8'h00;
        end else begin
          wideC[c] <= shifted | (replicate ? ({COMP_W{msb}} & lowMask) : 8'h00);
        end
      end
    end
  endgenerate

  assign wideOut = '{red: wideC[0], green: wideC[1], blue: wideC[2]};

  a_zero_fill: assert property (@(posedge clk) disable iff (!rstn)
    !replicate && compWidth == 4'h5 |=> wideC[0][2:0] == 3'h0)
    else $error("zero fill broken");
  a_msb_copy: assert property (@(posedge clk) disable iff (!rstn)
    replicate && compWidth == 4'h5 |=> wideC[1][2:0] == {3{wideC[1][7]}})
    else $error("msb replication broken");
endmodule : dlc_expand
`default_nettype wire

// *** tb/test_dlc_regs.sv ***
// self-checking bench for the display layer register bank
// drives the register port and the pipeline pulses itself, one clock
`timescale 1ns/10ps
`default_nettype none
module test_dlc_regs
  import dlc_pkg::*;
;
  logic clk;
  logic rstn;
  logic [31:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  dlc_events_t events;
  logic frameStart;
  logic frameEnd;
  logic headTaken;
  logic [3:0] compWidth;
  dlc_rgb_t pixelIn;
  logic [31:0] rowStride;
  logic [3:0] lookupBits;
  dlc_rgb_t baseColour;
  logic overlayOn;
  logic overlayAbort;
  logic attrApply;
  logic headRequest;
  logic irq;
  logic [31:0] rdVal;
  logic [31:0] addrs [12];
  logic [7:0] raw [3];
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;

  dlc_regs dlc_regs_i (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .events(events), .frameStart(frameStart),
    .frameEnd(frameEnd), .headTaken(headTaken), .compWidth(compWidth),
    .pixelIn(pixelIn), .rowStride(rowStride), .lookupBits(lookupBits),
    .baseColour(baseColour), .overlayOn(overlayOn), .overlayAbort(overlayAbort),
    .attrApply(attrApply), .headRequest(headRequest), .irq(irq)
  );

  task automatic final_report;
    if (n_fail == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    #1;
  endtask : wr

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1;
    rdVal = regRdata;
    chk(what, exp, rdVal);
  endtask : rchk

  // one-cycle pulse on {headTaken, frameEnd, frameStart, events}
  task automatic kick(input logic [7:0] v);
    @(posedge clk);
    {headTaken, frameEnd, frameStart, events} <= v;
    @(posedge clk);
    {headTaken, frameEnd, frameStart, events} <= 8'h00;
    #1;
  endtask : kick

  function automatic logic [7:0] expc(input logic [7:0] c, input int w, input logic bit_replicate_select);
    logic [7:0] v;
    v = c << (8 - w);
    if (bit_replicate_select && c[w-1]) begin
      v = v | (8'hFF >> w);
    end
    return v;
  endfunction : expc

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    rstn = 1'h0;
    regAddr = 32'h00000000;
    regWdata = 32'h00000000;
    regWr = 1'h0;
    regRd = 1'h0;
    {headTaken, frameEnd, frameStart, events} = 8'h00;
    compWidth = 4'h8;
    pixelIn = 24'h000000;
    addrs = '{OFF_LOOKUP_CFG, OFF_ROW_STRIDE, OFF_DEF_COLOUR, OFF_PATH_SEL, OFF_CH_ENABLE,
      OFF_CH_DISABLE, OFF_CH_STATE, OFF_IRQ_SET, OFF_IRQ_CLEAR, OFF_IRQ_MASK,
      OFF_IRQ_STATUS, 32'hF8038200};
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    // reset values, write-only and unmapped read zero
    foreach (addrs[i]) rchk("reset read", addrs[i], 32'h00000000);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_LOOKUP_CFG, 32'hFFFFFCFF | (32'(m) << 8));
      @(posedge clk);
      #1;
      chk("lookupBits", 32'h1 << m, {28'h0, lookupBits});
      rchk("lookup reg", OFF_LOOKUP_CFG, 32'(m) << 8);
    end
    wr(OFF_ROW_STRIDE, 32'hA5C30F81);
    chk("rowStride", 32'hA5C30F81, rowStride);
    rchk("stride reg", OFF_ROW_STRIDE, 32'hA5C30F81);
    // default colour on the base layer
    wr(OFF_DEF_COLOUR, 32'hFF123456);
    wr(OFF_PATH_SEL, 32'hFFFFFCFF);
    rchk("colour reg", OFF_DEF_COLOUR, 32'h00123456);
    rchk("path reg", OFF_PATH_SEL, 32'h00000000);
    chk("baseColour", 32'h00123456, {8'h00, baseColour});
    // widening with zero or msb fill
    for (int k = 0; k < 4; k++) begin
      wr(OFF_PATH_SEL, {22'h0, k[0], 1'h1, 8'h00});
      raw = '{8'hFF >> (8 - 3 - 2 * k[1]), 8'h01, 8'h01 << (2 + 2 * k[1])};
      @(posedge clk);
      compWidth <= 4'(3 + 2 * k[1]);
      pixelIn <= {raw[0], raw[1], raw[2]};
      repeat (3) @(posedge clk);
      #1;
      chk("expanded", {8'h00, expc(raw[0], 3 + 2 * k[1], k[0]), expc(raw[1], 3 + 2 * k[1],
        k[0]), expc(raw[2], 3 + 2 * k[1], k[0])}, {8'h00, baseColour});
    end
    // width 0 taken as full width, nothing widened
    @(posedge clk);
    compWidth <= 4'h0;
    pixelIn <= 24'h123456;
    repeat (3) @(posedge clk);
    #1;
    chk("full width", 32'h00123456, {8'h00, baseColour});
    wr(OFF_CH_ENABLE, 32'h00000000);
    chk("overlayOn zero write", 32'h0, {31'h0, overlayOn});
    wr(OFF_CH_ENABLE, 32'h00000001);
    chk("overlayOn", 32'h1, {31'h0, overlayOn});
    rchk("state on", OFF_CH_STATE, 32'h00000001);
    wr(OFF_CH_DISABLE, 32'h00000001);
    chk("overlayOn stopping", 32'h1, {31'h0, overlayOn});
    kick(8'h40);
    chk("overlayOn after frame", 32'h0, {31'h0, overlayOn});
    wr(OFF_CH_ENABLE, 32'h00000001);
    wr(OFF_CH_DISABLE, 32'h00000100);
    chk("overlayAbort", 32'h1, {31'h0, overlayAbort});
    chk("overlayOn abort", 32'h0, {31'h0, overlayOn});
    @(posedge clk);
    #1;
    chk("overlayAbort end", 32'h0, {31'h0, overlayAbort});
    wr(OFF_CH_ENABLE, 32'h00000002);
    rchk("state attr", OFF_CH_STATE, 32'h00000002);
    kick(8'h20);
    chk("attrApply", 32'h1, {31'h0, attrApply});
    @(posedge clk);
    #1;
    chk("attrApply end", 32'h0, {31'h0, attrApply});
    rchk("state attr done", OFF_CH_STATE, 32'h00000000);
    wr(OFF_CH_ENABLE, 32'h00000004);
    chk("headRequest", 32'h1, {31'h0, headRequest});
    rchk("state head", OFF_CH_STATE, 32'h00000004);
    kick(8'h80);
    chk("headRequest done", 32'h0, {31'h0, headRequest});
    rchk("state head done", OFF_CH_STATE, 32'h00000000);
    wr(OFF_IRQ_SET, 32'hFFFFFFFF);
    rchk("mask all", OFF_IRQ_MASK, 32'h0000007C);
    wr(OFF_IRQ_CLEAR, 32'h00000014);
    wr(OFF_IRQ_SET, 32'h00000000);
    wr(OFF_IRQ_CLEAR, 32'h00000000);
    rchk("mask part", OFF_IRQ_MASK, 32'h00000068);
    // each source sets, interrupts if enabled, clears on read
    for (int i = 0; i < 5; i++) begin
      kick(8'h01 << i);
      chk("irq", (32'h00000068 >> (i + 2)) & 32'h1, {31'h0, irq});
      rchk("status", OFF_IRQ_STATUS, 32'h00000004 << i);
      chk("irq after read", 32'h0, {31'h0, irq});
      rchk("status cleared", OFF_IRQ_STATUS, 32'h00000000);
    end
    // event in the read cycle survives the clear
    @(posedge clk);
    regAddr <= OFF_IRQ_STATUS;
    regRd <= 1'h1;
    events <= 5'h10;
    @(posedge clk);
    regRd <= 1'h0;
    events <= 5'h00;
    #1;
    chk("status race read", 32'h0, regRdata);
    chk("irq race", 32'h1, {31'h0, irq});
    rchk("status race kept", OFF_IRQ_STATUS, 32'h00000040);
    final_report();
  end
endmodule : test_dlc_regs
`default_nettype wire
